// file: motor_inhibit_pkg.sv
// Shared constants and carrier types for the motor start-inhibit logic
package motor_inhibit_pkg;

    // ==========================================================
    // Widths
    localparam int CUR_W = 16;
    localparam int SEC_W = 16;
    localparam int CNT_W = 4;

    // ==========================================================
    // Time base
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_PERIOD_S = 1;
    localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;

    // ==========================================================
    // Times in seconds and reset values
    localparam logic [SEC_W-1:0] HOUR_S = 16'h0E10;
    localparam logic [SEC_W-1:0] RUN_LIMIT_S = 16'h0258;
    localparam logic [SEC_W-1:0] STOPPED_RST = 16'hFFFF;
    localparam logic [SEC_W-1:0] SINCE_START_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] COUNT_RST = 4'h0;

    // ==========================================================
    // Start detection: current above this share of full load
    localparam logic [7:0] START_PCT = 8'h1E;
    localparam logic [7:0] PCT_FULL = 8'h64;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [CUR_W-1:0] phaseA;
        logic [CUR_W-1:0] phaseB;
        logic [CUR_W-1:0] phaseC;
    } phase_current_t;

    typedef struct packed {
        logic [CUR_W-1:0] fullLoadCurrent;
        logic [CUR_W-1:0] stopCurrentLevel;
        logic [CNT_W-1:0] coldStartLimit;
        logic [CNT_W-1:0] hourlyStartLimit;
        logic intervalLimitEnable;
        logic hourlyLimitEnable;
        logic [SEC_W-1:0] intervalWaitTime;
        logic backspinEnable;
        logic [SEC_W-1:0] backspinWaitTime;
        logic thermalBlockEnable;
        logic [CUR_W-1:0] thermalAlarmLevel;
        logic remoteBlockEnable;
    } settings_t;

    typedef struct packed {
        logic startInhibit;
        logic hourlyLimitBlock;
        logic intervalLimitBlock;
        logic backspinWaitActive;
        logic thermalInhibit;
        logic remoteInhibit;
        logic coldSequenceFlag;
        logic coldCountBlock;
        logic hourlyLimitPrealarm;
        logic motorRunning;
        logic [CNT_W-1:0] coldStartsLeft;
        logic [CNT_W-1:0] hourlyStartsLeft;
        logic [SEC_W-1:0] hourlyBlockTimeLeft;
        logic [SEC_W-1:0] intervalBlockTimeLeft;
        logic [SEC_W-1:0] backspinTimeLeft;
    } status_t;

endpackage

// file: sec_countdown.sv
// Loadable seconds countdown used by the start-inhibit timers
`timescale 1ns/1ps
`default_nettype none

module sec_countdown #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic [W-1:0] remaining,
    output logic zero,
    output logic expired
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    // ==========================================================
    // Count selection
    // A zero load expires at once, in the same cycle as the load itself
    assign zero = (count_r == '0);
    assign expired = (load && (loadValue == '0)) || (!load && tick && (count_r == W'(1)));
    assign count_nxt = load ? loadValue : ((tick && !zero) ? count_r - W'(1) : count_r);
    assign remaining = count_r;

    // Counter register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

endmodule

`default_nettype wire

// file: motor_start_inhibit.sv
// Motor start-inhibit logic: cold starts, interval and hourly limits, backspin, blocks
//
// Overview of operation
// - Raise hourly block when configured starts per hour are used up.
// - Raise interval block while the wait since last start runs.
// - Combined inhibit when backspin, interval, hourly, thermal or remote block active.
// - Interval and hourly blocks ignored for inhibit during a cold sequence.
// - Cold-count block alone never raises the combined inhibit.
// - Starting while inhibited sets the override flag.
// - Override flag clears only on manual reset.
// - First cold start needs one hour stopped, or longer enabled interval.
// - Further starts join the sequence until the cold limit is reached.
// - Running beyond ten minutes ends an unfinished cold sequence.
// - Reaching cold limit raises cold-count block and starts interval timer.
// - Interval expiry during cold-count block ends sequence, releases block.
// - Hourly counting begins at the last start of a finished sequence.
// - Pre-alarm when the hourly block would come at the next stop.
// - Remaining cold starts, hourly starts and block times are readable.
// - Hourly block holds until its remaining time reaches zero.
// - After trip or stop, backspin block holds for configured seconds.
// - Backspin function has an enable; disabled means no backspin block.
// - Thermal block when enabled and thermal usage above alarm level.
// - Remote block when enabled, from the digital input.
// - Start detected when current rises above 30 percent of full load.
// - Stop detected when all three phases fall below stop level.
`timescale 1ns/1ps
`default_nettype none

module motor_start_inhibit #(
    parameter int TICK_CYCLES = motor_inhibit_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire motor_inhibit_pkg::phase_current_t phaseCurrent,
    input wire motor_inhibit_pkg::settings_t settings,
    input wire logic [motor_inhibit_pkg::CUR_W-1:0] thermalUsed,
    input wire logic remoteInput,
    input wire logic tripEvent,
    input wire logic manualReset,
    output motor_inhibit_pkg::status_t status,
    output logic overrideStartFlag
);

    localparam int SW = motor_inhibit_pkg::SEC_W;
    localparam int CW = motor_inhibit_pkg::CNT_W;
    localparam int PW = motor_inhibit_pkg::CUR_W + 8;

    // ==========================================================
    // Remote input synchroniser; it comes from a pin
    logic remoteMeta_r;
    logic remoteSync_r;

    always_ff @(posedge ref_clk)
    begin
        remoteMeta_r <= rst ? 1'b0 : remoteInput;
        remoteSync_r <= rst ? 1'b0 : remoteMeta_r;
    end

    // ==========================================================
    // One-second time base; parameter lets simulation shorten it
    logic [31:0] tickCnt_r;
    logic tick;

    assign tick = (tickCnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk)
    begin
        if (rst || tick)
            tickCnt_r <= 32'h0000_0000;
        else
            tickCnt_r <= tickCnt_r + 32'h0000_0001;
    end

    // ==========================================================
    // Start and stop detection from phase currents
    logic [motor_inhibit_pkg::CUR_W-1:0] maxAB;
    logic [motor_inhibit_pkg::CUR_W-1:0] maxCur;
    logic [PW-1:0] scaledCur;
    logic [PW-1:0] scaledStart;
    logic allBelowStop;
    logic running_r;
    logic startEvt;
    logic stopEvt;

    assign maxAB = (phaseCurrent.phaseA > phaseCurrent.phaseB) ? phaseCurrent.phaseA
                                                               : phaseCurrent.phaseB;
    assign maxCur = (maxAB > phaseCurrent.phaseC) ? maxAB : phaseCurrent.phaseC;
    // Compare scaled values so no divider is needed
    assign scaledCur = PW'(maxCur) * PW'(motor_inhibit_pkg::PCT_FULL);
    assign scaledStart = PW'(settings.fullLoadCurrent) * PW'(motor_inhibit_pkg::START_PCT);
    assign allBelowStop = (phaseCurrent.phaseA < settings.stopCurrentLevel)
                       && (phaseCurrent.phaseB < settings.stopCurrentLevel)
                       && (phaseCurrent.phaseC < settings.stopCurrentLevel);
    assign startEvt = !running_r && (scaledCur > scaledStart);
    assign stopEvt = running_r && allBelowStop;

    // Run state follows detected events
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            running_r <= 1'b0;
        else if (startEvt || stopEvt)
            running_r <= startEvt;
    end

    // ==========================================================
    // Seconds stopped and seconds since last start, saturating
    logic [SW-1:0] stoppedSecs_r;
    logic [SW-1:0] sinceStart_r;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            stoppedSecs_r <= motor_inhibit_pkg::STOPPED_RST;
        else if (running_r || startEvt)
            stoppedSecs_r <= '0;
        else if (tick && stoppedSecs_r != '1)
            stoppedSecs_r <= stoppedSecs_r + SW'(1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            sinceStart_r <= motor_inhibit_pkg::SINCE_START_RST;
        else if (startEvt)
            sinceStart_r <= '0;
        else if (tick && sinceStart_r != '1)
            sinceStart_r <= sinceStart_r + SW'(1);
    end

    // ==========================================================
    // Cold-start sequence tracking
    logic [SW-1:0] coldQualify;
    logic coldFirst;
    logic coldSeq_r;
    logic coldSeq_nxt;
    logic [CW-1:0] coldCount_r;
    logic [CW-1:0] coldCount_nxt;
    logic coldBlock_r;
    logic coldBlock_nxt;
    logic coldLimitHit;
    logic seqEnd;
    logic intervalExpired;

    // A longer enabled interval replaces the one-hour rest
    assign coldQualify = (settings.intervalLimitEnable
                          && settings.intervalWaitTime > motor_inhibit_pkg::HOUR_S)
                         ? settings.intervalWaitTime : motor_inhibit_pkg::HOUR_S;
    assign coldFirst = (stoppedSecs_r >= coldQualify) && (settings.coldStartLimit != '0);

    always_comb
    begin
        coldSeq_nxt = coldSeq_r;
        coldCount_nxt = coldCount_r;
        coldBlock_nxt = coldBlock_r;
        coldLimitHit = 1'b0;
        seqEnd = 1'b0;
        if (startEvt)
        begin
            if (coldFirst)
            begin
                coldSeq_nxt = 1'b1;
                coldCount_nxt = CW'(1);
            end
            else if (coldSeq_r && coldCount_r < settings.coldStartLimit)
                coldCount_nxt = coldCount_r + CW'(1);
            if (coldSeq_nxt && !coldBlock_r && coldCount_nxt >= settings.coldStartLimit)
            begin
                coldBlock_nxt = 1'b1;
                coldLimitHit = 1'b1;
            end
        end
        else if (coldSeq_r && !coldBlock_r && running_r
                 && sinceStart_r > motor_inhibit_pkg::RUN_LIMIT_S)
        begin
            coldSeq_nxt = 1'b0;
            seqEnd = 1'b1;
        end
        else if (coldBlock_r && intervalExpired)
        begin
            coldSeq_nxt = 1'b0;
            coldBlock_nxt = 1'b0;
            seqEnd = 1'b1;
        end
    end

    // Sequence registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            coldSeq_r <= 1'b0;
            coldCount_r <= motor_inhibit_pkg::COUNT_RST;
            coldBlock_r <= 1'b0;
        end
        else
        begin
            coldSeq_r <= coldSeq_nxt;
            coldCount_r <= coldCount_nxt;
            coldBlock_r <= coldBlock_nxt;
        end
    end

    // ==========================================================
    // Interval timer: normal starts, or the cold limit being reached
    logic intervalLoad;
    logic intervalZero;
    logic [SW-1:0] intervalLeft;

    assign intervalLoad = (startEvt && !coldSeq_nxt && settings.intervalLimitEnable)
                       || coldLimitHit;

    sec_countdown #(.W(SW)) intervalTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick),
        .load(intervalLoad),
        .loadValue(settings.intervalWaitTime),
        .remaining(intervalLeft),
        .zero(intervalZero),
        .expired(intervalExpired)
    );

    // ==========================================================
    // Hourly window: counts starts outside cold sequences
    logic hourLoad;
    logic [SW-1:0] hourLoadValue;
    logic [SW-1:0] hourRest;
    logic hourZero;
    logic [SW-1:0] hourLeft;
    logic [CW-1:0] hourCount_r;
    logic hourNormalStart;
    logic hourUsedUp;

    // Window seeded from the final start of a finished sequence
    assign hourRest = (sinceStart_r >= motor_inhibit_pkg::HOUR_S) ? SW'(1)
                      : motor_inhibit_pkg::HOUR_S - sinceStart_r;
    assign hourNormalStart = startEvt && !coldSeq_nxt;
    assign hourLoad = seqEnd || (hourNormalStart && hourZero);
    assign hourLoadValue = seqEnd ? hourRest : motor_inhibit_pkg::HOUR_S;
    assign hourUsedUp = settings.hourlyLimitEnable && !hourZero
                     && (hourCount_r >= settings.hourlyStartLimit);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            hourCount_r <= motor_inhibit_pkg::COUNT_RST;
        else if (hourLoad)
            hourCount_r <= CW'(1);
        else if (hourNormalStart && hourCount_r != '1)
            hourCount_r <= hourCount_r + CW'(1);
    end

    sec_countdown #(.W(SW)) hourTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick),
        .load(hourLoad),
        .loadValue(hourLoadValue),
        .remaining(hourLeft),
        .zero(hourZero),
        .expired()
    );

    // ==========================================================
    // Backspin timer, loaded on trip or stop
    logic backspinLoad;
    logic backspinZero;
    logic [SW-1:0] backspinLeft;

    assign backspinLoad = settings.backspinEnable && (stopEvt || tripEvent);

    sec_countdown #(.W(SW)) backspinTimer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick),
        .load(backspinLoad),
        .loadValue(settings.backspinWaitTime),
        .remaining(backspinLeft),
        .zero(backspinZero),
        .expired()
    );

    // ==========================================================
    // Block reasons and combined inhibit
    logic hourlyBlk;
    logic intervalBlk;
    logic backspinBlk;
    logic thermalBlk;
    logic remoteBlk;
    logic inhibitNow;

    assign hourlyBlk = hourUsedUp && !running_r;
    assign intervalBlk = settings.intervalLimitEnable && !intervalZero;
    assign backspinBlk = settings.backspinEnable && !backspinZero;
    assign thermalBlk = settings.thermalBlockEnable
                     && (thermalUsed > settings.thermalAlarmLevel);
    assign remoteBlk = settings.remoteBlockEnable && remoteSync_r;
    // Cold-count block deliberately left out of the sum
    assign inhibitNow = backspinBlk || thermalBlk || remoteBlk
                     || (!coldSeq_r && (hourlyBlk || intervalBlk));

    // ==========================================================
    // Override flag: set wins over a manual clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            overrideStartFlag <= 1'b0;
        else if (startEvt && inhibitNow)
            overrideStartFlag <= 1'b1;
        else if (manualReset)
            overrideStartFlag <= 1'b0;
    end

    // ==========================================================
    // Registered status word
    motor_inhibit_pkg::status_t status_nxt;

    always_comb
    begin
        status_nxt.startInhibit = inhibitNow;
        status_nxt.hourlyLimitBlock = hourlyBlk;
        status_nxt.intervalLimitBlock = intervalBlk;
        status_nxt.backspinWaitActive = backspinBlk;
        status_nxt.thermalInhibit = thermalBlk;
        status_nxt.remoteInhibit = remoteBlk;
        status_nxt.coldSequenceFlag = coldSeq_r;
        status_nxt.coldCountBlock = coldBlock_r;
        status_nxt.hourlyLimitPrealarm = hourUsedUp && running_r;
        status_nxt.motorRunning = running_r;
        status_nxt.coldStartsLeft = coldSeq_r ? settings.coldStartLimit - coldCount_r
                                              : settings.coldStartLimit;
        status_nxt.hourlyStartsLeft = (hourZero || hourCount_r >= settings.hourlyStartLimit)
                                      ? (hourZero ? settings.hourlyStartLimit : '0)
                                      : settings.hourlyStartLimit - hourCount_r;
        status_nxt.hourlyBlockTimeLeft = hourlyBlk ? hourLeft : '0;
        status_nxt.intervalBlockTimeLeft = intervalBlk ? intervalLeft : '0;
        status_nxt.backspinTimeLeft = backspinBlk ? backspinLeft : '0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            status <= '0;
        else
            status <= status_nxt;
    end

    // ==========================================================
    // Assertions and covers
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_hourly_block;
        hourUsedUp && !running_r |=> status.hourlyLimitBlock;
    endproperty
    a_hourly_block: assert property (p_hourly_block) else $error("hourly block missing");

    property p_interval_block;
        intervalLoad && settings.intervalLimitEnable && settings.intervalWaitTime != '0
        |=> ##1 status.intervalLimitBlock;
    endproperty
    a_interval_block: assert property (p_interval_block) else $error("interval block missing");

    property p_inhibit_sum;
        (backspinBlk || thermalBlk || remoteBlk) |=> status.startInhibit;
    endproperty
    a_inhibit_sum: assert property (p_inhibit_sum) else $error("inhibit not raised");

    property p_cold_ignores;
        coldSeq_r && !backspinBlk && !thermalBlk && !remoteBlk |=> !status.startInhibit;
    endproperty
    a_cold_ignores: assert property (p_cold_ignores) else $error("limits used in sequence");

    property p_override_set;
        startEvt && inhibitNow |=> overrideStartFlag;
    endproperty
    a_override_set: assert property (p_override_set) else $error("override not set");

    property p_override_hold;
        overrideStartFlag && !manualReset |=> overrideStartFlag;
    endproperty
    a_override_hold: assert property (p_override_hold) else $error("override lost");

    property p_cold_limit;
        coldLimitHit |=> coldBlock_r && coldSeq_r;
    endproperty
    a_cold_limit: assert property (p_cold_limit) else $error("cold block not raised");

    property p_long_run_ends;
        coldSeq_r && !coldBlock_r && running_r && !startEvt
        && sinceStart_r > motor_inhibit_pkg::RUN_LIMIT_S |=> !coldSeq_r;
    endproperty
    a_long_run_ends: assert property (p_long_run_ends) else $error("sequence not ended");

    property p_backspin_off;
        !settings.backspinEnable |=> !status.backspinWaitActive;
    endproperty
    a_backspin_off: assert property (p_backspin_off) else $error("backspin while disabled");

    property p_backspin_stop;
        stopEvt && settings.backspinEnable && settings.backspinWaitTime != '0
        ##1 settings.backspinEnable |=> status.backspinWaitActive;
    endproperty
    a_backspin_stop: assert property (p_backspin_stop) else $error("backspin not started");

    property p_tick_gap;
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

    c_cold_first: cover property (startEvt && coldFirst);
    c_seq_end: cover property (seqEnd);
    c_override: cover property (!overrideStartFlag ##1 overrideStartFlag);
    c_hourly: cover property (status.hourlyLimitBlock);

endmodule

`default_nettype wire

// file: motor_plant_model.sv
// Behavioural motor plant: phase currents follow a run command
`timescale 1ns/1ps
`default_nettype none

module motor_plant_model (
    input wire logic ref_clk,
    input wire logic run,
    output motor_inhibit_pkg::phase_current_t phaseCurrent
);
    // ====
    // Currents
    // Full load on all phases when running, zero when stopped, moved at the edge only
    always @(posedge ref_clk)
    begin
        phaseCurrent <= run ? {3{16'h0064}} : '0;
    end
endmodule

`default_nettype wire

// file: motor_start_inhibit_tb.sv
// Self-checking bench for the motor start-inhibit block
`timescale 1ns/1ps
`default_nettype none

module motor_start_inhibit_tb;
    // ====
    // Signals
    typedef struct packed {
        logic te;
        logic [15:0] tu;
        logic re;
        logic ri;
        logic [2:0] exp;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic tripEvent = 1'b0;
    logic manualReset = 1'b0;
    logic remoteInput = 1'b0;
    logic [15:0] thermalUsed = 16'h0000;
    motor_inhibit_pkg::settings_t settings = '0;
    motor_inhibit_pkg::phase_current_t phaseCurrent;
    motor_inhibit_pkg::status_t status;
    logic overrideStartFlag;
    int miscompares = 0;
    int checksDone = 0;
    int cycles = 0;
    int n;
    // Thermal and remote cases, boundary level included: {therm, remote, inhibit}
    row_t rows [5] = '{
        '{1'b1, 16'h0033, 1'b0, 1'b0, 3'b101},
        '{1'b1, 16'h0032, 1'b0, 1'b0, 3'b000},
        '{1'b0, 16'h0063, 1'b0, 1'b0, 3'b000},
        '{1'b0, 16'h0000, 1'b1, 1'b1, 3'b011},
        '{1'b0, 16'h0000, 1'b0, 1'b1, 3'b000}};

    // ====
    // Clock, design and plant
    // Short tick keeps the hour at 36000 cycles
    always #20 ref_clk = ~ref_clk;
    motor_start_inhibit #(.TICK_CYCLES(10)) uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .phaseCurrent(phaseCurrent),
        .settings(settings),
        .thermalUsed(thermalUsed),
        .remoteInput(remoteInput),
        .tripEvent(tripEvent),
        .manualReset(manualReset),
        .status(status),
        .overrideStartFlag(overrideStartFlag)
    );
    motor_plant_model plant (
        .ref_clk(ref_clk),
        .run(run),
        .phaseCurrent(phaseCurrent)
    );

    // ====
    // Tasks
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    // Sampling at the falling edge keeps reads clear of the launch edge
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic drive_run(input logic v);
        @(posedge ref_clk);
        run <= v;
        cyc(6);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard: a whole run needs about 42000 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 50000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    // ====
    // Main sequence
    initial
    begin
        settings.fullLoadCurrent = 16'h0064;
        settings.stopCurrentLevel = 16'h000A;
        settings.coldStartLimit = 4'h2;
        settings.hourlyStartLimit = 4'h2;
        settings.intervalLimitEnable = 1'b1;
        settings.hourlyLimitEnable = 1'b1;
        settings.intervalWaitTime = 16'h0005;
        settings.backspinWaitTime = 16'h0003;
        settings.thermalAlarmLevel = 16'h0032;
        cyc(3);
        chk_val({15'h0000, status.startInhibit}, 16'h0000, "reset inhibit");
        @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        chk_bit(overrideStartFlag, 1'b0, "reset override");
        foreach (rows[i])
        begin
            @(posedge ref_clk);
            settings.thermalBlockEnable <= rows[i].te;
            thermalUsed <= rows[i].tu;
            settings.remoteBlockEnable <= rows[i].re;
            remoteInput <= rows[i].ri;
            cyc(6);
            chk_bit(status.thermalInhibit, rows[i].exp[2], "thermal");
            chk_bit(status.remoteInhibit, rows[i].exp[1], "remote");
            chk_bit(status.startInhibit, rows[i].exp[0], "inhibit");
        end
        // Trip with backspin off, then on; the wait is counted in cycles
        @(posedge ref_clk);
        tripEvent <= 1'b1;
        @(posedge ref_clk);
        tripEvent <= 1'b0;
        cyc(3);
        chk_bit(status.backspinWaitActive, 1'b0, "backspin off");
        @(posedge ref_clk);
        settings.backspinEnable <= 1'b1;
        tripEvent <= 1'b1;
        @(posedge ref_clk);
        tripEvent <= 1'b0;
        for (n = 0; n < 10 && status.backspinWaitActive !== 1'b1; n++) cyc(0);
        chk_val(status.backspinTimeLeft, 16'h0003, "backspin time");
        chk_bit(status.startInhibit, 1'b1, "backspin inhibit");
        for (n = 0; n < 100 && status.backspinWaitActive !== 1'b0; n++) cyc(0);
        chk_bit(n >= 20 && n <= 32, 1'b1, "backspin length");
        settings.backspinEnable <= 1'b0;
        // Cold sequence of two starts, then hourly limit of two
        drive_run(1'b1);
        chk_bit(status.coldSequenceFlag, 1'b1, "cold first");
        chk_val(status.coldStartsLeft, 16'h0001, "cold left");
        drive_run(1'b0);
        drive_run(1'b1);
        chk_bit(status.coldCountBlock, 1'b1, "cold block");
        chk_bit(status.startInhibit, 1'b0, "cold no inhibit");
        drive_run(1'b0);
        for (n = 0; n < 200 && status.coldCountBlock !== 1'b0; n++) cyc(0);
        chk_bit(status.coldSequenceFlag, 1'b0, "cold end");
        chk_val(status.hourlyStartsLeft, 16'h0001, "hourly left");
        drive_run(1'b1);
        chk_bit(status.intervalLimitBlock, 1'b1, "interval");
        chk_bit(status.hourlyLimitPrealarm, 1'b1, "prealarm");
        chk_bit(status.startInhibit, 1'b1, "interval inhibit");
        drive_run(1'b0);
        chk_bit(status.hourlyLimitBlock, 1'b1, "hourly block");
        for (n = 0; n < 40000 && status.hourlyLimitBlock !== 1'b0; n++) cyc(0);
        chk_bit(n > 35000 && n < 40000, 1'b1, "hourly length");
        chk_val(status.hourlyBlockTimeLeft, 16'h0000, "hourly hold");
        // Start against a thermal block, then clear by hand
        @(posedge ref_clk);
        settings.thermalBlockEnable <= 1'b1;
        thermalUsed <= 16'h0063;
        cyc(3);
        drive_run(1'b1);
        chk_bit(overrideStartFlag, 1'b1, "override set");
        drive_run(1'b0);
        cyc(20);
        chk_bit(overrideStartFlag, 1'b1, "override held");
        @(posedge ref_clk);
        manualReset <= 1'b1;
        @(posedge ref_clk);
        manualReset <= 1'b0;
        cyc(2);
        chk_bit(overrideStartFlag, 1'b0, "override clear");
        // Second reset makes the motor look long stopped, so the next start is cold
        @(posedge ref_clk);
        rst <= 1'b1;
        settings.thermalBlockEnable <= 1'b0;
        cyc(3);
        @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        chk_bit(status.startInhibit, 1'b0, "second reset inhibit");
        chk_val(status.coldStartsLeft, 16'h0002, "second reset cold left");
        // A cold start that runs past ten minutes ends the sequence
        drive_run(1'b1);
        chk_bit(status.coldSequenceFlag, 1'b1, "cold again");
        for (n = 0; n < 7000 && status.coldSequenceFlag !== 1'b0; n++) cyc(0);
        chk_bit(n > 5900 && n < 6100, 1'b1, "long run length");
        chk_val(status.hourlyStartsLeft, 16'h0001, "hourly after long run");
        // A stop, not only a trip, starts the backspin wait
        @(posedge ref_clk);
        settings.backspinEnable <= 1'b1;
        drive_run(1'b0);
        chk_bit(status.backspinWaitActive, 1'b1, "backspin after stop");
        report_and_stop();
    end
endmodule

`default_nettype wire
